// file: bench/far_side_model.sv
// Controller model: drives the bus clock pin and times the output pulses
`timescale 1ns/1ps

module far_side_model (
  input  wire logic        mclk,
  input  wire logic        hold_low,
  input  wire logic        sda_out,
  input  wire logic        sda_oe,
  output logic             scl_in,
  output logic             pin,
  output logic      [15:0] high_len,
  output logic      [15:0] period_len
);
  logic [15:0] hi_cnt  = 16'h0000;
  logic [15:0] per_cnt = 16'h0000;
  logic        pin_q   = 1'b0;

  // Pull-up on the pin: a released or open-drain high reads as one
  assign pin    = (sda_oe && !sda_out) ? 1'b0 : 1'b1;
  // Clock held high while pulse output is wanted
  assign scl_in = !hold_low;

  always_ff @(posedge mclk) begin
    pin_q <= pin;
    if (pin && !pin_q) begin
      period_len <= per_cnt;
      per_cnt    <= 16'h0001;
      hi_cnt     <= 16'h0001;
    end else begin
      per_cnt <= per_cnt + 16'h0001;
      hi_cnt  <= hi_cnt + {15'h0000, pin};
    end
    if (!pin && pin_q) begin
      high_len <= hi_cnt;
    end
  end
endmodule : far_side_model

// file: bench/tb_top.sv
// Self-checking bench for the temperature pulse and relay output
`timescale 1ns/1ps
`include "temp_pwm_defs.svh"

module tb_top
  import temp_pwm_pkg::*;
;
  localparam int PL2 = 11;
  localparam int P   = 2048;
  localparam int REQ = 40;
  logic        mclk;
  logic        nrst;
  reg_req_s    reg_req;
  logic [15:0] reg_rdata;
  logic        scl_in;
  logic        pin;
  logic        fatal;
  logic        sda_out;
  logic        sda_oe;
  logic        bus_mode;
  logic        hold_low;
  logic [15:0] high_len;
  logic [15:0] period_len;
  int          mismatches;
  int          n_tests;
  logic [15:0] tv [5] = '{16'h6AB3, 16'h7E3B, 16'hFFFF, 16'h0000, 16'h7477};
  logic [9:0]  cv [5] = '{10'h000, 10'h3FF, 10'h3FF, 10'h000, 10'h1FF};
  logic [15:0] rt [6] = '{16'h3686, 16'h3654, 16'h3622, 16'h3654, 16'h3687, 16'h3621};
  logic        rl [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  always #25 mclk = ~mclk;

  temp_pwm_output #(.PERIOD_LOG2(PL2), .REQ_CYCLES(REQ)) dut (
    .mclk(mclk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .scl_in(scl_in), .sda_in(pin), .fatal_error_indication(fatal),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_mode(bus_mode)
  );
  far_side_model peer (
    .mclk(mclk), .hold_low(hold_low), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_in(scl_in), .pin(pin), .high_len(high_len), .period_len(period_len)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge mclk);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    #1 chk("read data", exp, reg_rdata & m);
  endtask : rd

  // Stored words only take effect at the next reset, like a power cycle
  task automatic rst();
    nrst <= 1'b0;
    cyc(4);
    nrst <= 1'b1;
    cyc(24);
  endtask : rst

  // Code is latched at period start, so allow three full periods to settle
  task automatic meas(input logic [15:0] hi);
    cyc(3 * P);
    #1 chk("high time", hi, high_len);
    chk("period", 16'h0800, period_len);
  endtask : meas

  task automatic want_bus();
    int i;
    hold_low <= 1'b1;
    for (i = 0; i < REQ + 20 && bus_mode !== 1'b1; i++) @(negedge mclk);
    // Hold a little past the switch so the long-request check is reached
    cyc(4);
    hold_low <= 1'b0;
    chk("bus entry", 16'h0001, {15'h0000, bus_mode});
    chk("pin released", 16'h0000, {15'h0000, sda_oe});
    if (bus_mode !== 1'b1) stop_test();
  endtask : want_bus

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    reg_req = '0;
    fatal = 1'b0;
    hold_low = 1'b0;
    mismatches = 0;
    n_tests = 0;
    cyc(4);
    nrst <= 1'b1;
    cyc(24);
    // --------------------------------------------------------------------------
    // Defaults, read-only status and an unmapped index
    // --------------------------------------------------------------------------
    chk("bus after power-on", 16'h0001, {15'h0000, bus_mode});
    rd(6'h02, 16'hFFFF, 16'h0000);
    rd(6'h20, 16'hFFFF, 16'hFFFF);
    rd(6'h21, 16'hFFFF, 16'h0000);
    rd(6'h23, 16'hFFFF, 16'hFF00);
    wr(6'h0F, 16'hFFFF);
    rd(6'h0F, 16'h000F, 16'h0008);
    rd(6'h3F, 16'hFFFF, 16'h0000);
    // --------------------------------------------------------------------------
    // Die temperature, push-pull pulses, error band and clamping
    // --------------------------------------------------------------------------
    wr(6'h02, 16'h0005);
    rst();
    wr(6'h06, 16'h3DD4);
    meas(16'h02FF);
    rd(6'h0F, 16'hFFC0, 16'h7FC0);
    @(posedge mclk);
    fatal <= 1'b1;
    meas(16'h0700);
    rd(6'h0F, 16'h0010, 16'h0010);
    @(posedge mclk);
    fatal <= 1'b0;
    wr(6'h06, 16'h4DC4);
    meas(16'h04FF);
    wr(6'h06, 16'h0100);
    meas(16'h0100);
    // --------------------------------------------------------------------------
    // Object temperature over a stored range, then switch requests
    // --------------------------------------------------------------------------
    wr(6'h02, 16'h0035);
    wr(6'h20, 16'h7E3B);
    wr(6'h21, 16'h6AB3);
    rst();
    for (int i = 0; i < 5; i++) begin
      wr(6'h07, tv[i]);
      meas(16'h0100 + {6'h00, cv[i]});
    end
    hold_low <= 1'b1;
    cyc(REQ - 10);
    hold_low <= 1'b0;
    cyc(10);
    chk("short low kept pulses", 16'h0000, {15'h0000, bus_mode});
    want_bus();
    cyc(P);
    chk("bus kept", 16'h0001, {15'h0000, bus_mode});
    rst();
    chk("pulses after reset", 16'h0000, {15'h0000, bus_mode});
    chk("pin driven after reset", 16'h0001, {15'h0000, sda_oe});
    // --------------------------------------------------------------------------
    // Open-drain relay with hysteresis, then a request from relay mode
    // --------------------------------------------------------------------------
    wr(6'h02, 16'h0033);
    wr(6'h21, 16'h3654);
    wr(6'h20, 16'h0032);
    rst();
    cyc(300);
    chk("relay start low", 16'h0000, {15'h0000, pin});
    for (int i = 0; i < 6; i++) begin
      wr(6'h07, rt[i]);
      cyc(300);
      chk("relay level", {15'h0000, rl[i]}, {15'h0000, pin});
      chk("open-drain value", 16'h0000, {15'h0000, sda_out});
    end
    want_bus();
    wr(6'h02, 16'h0032);
    rst();
    chk("relay needs enable", 16'h0001, {15'h0000, bus_mode});
    stop_test();
  end
endmodule : tb_top

// file: bench/temp_pwm_output_monitor.sv
// Assertion checker for the temperature pulse and relay output, bound to its ports
`timescale 1ns/1ps
`include "temp_pwm_defs.svh"

module temp_pwm_output_monitor
  import temp_pwm_pkg::*;
#(
  parameter int PERIOD_LOG2 = 13,
  parameter int REQ_CYCLES  = 28800
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire reg_req_s    reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        fatal_error_indication,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        bus_mode
);
  localparam int P = 1 << PERIOD_LOG2;
  logic [15:0] low_cnt;
  logic [15:0] hi_cnt;
  logic [7:0]  since_rst;
  logic        lvl;

  // Pin level as the far side sees it, pull-up included
  assign lvl = !(sda_oe && !sda_out);

  // --------------------------------------------------------------------------
  // Helper counters, saturating so long idle stretches never wrap
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_cnt   <= 16'h0000;
      hi_cnt    <= 16'h0000;
      since_rst <= 8'h00;
    end else begin
      low_cnt   <= scl_in ? 16'h0000 : low_cnt + {15'h0000, low_cnt != 16'hFFFF};
      hi_cnt    <= !lvl ? 16'h0000 : hi_cnt + {15'h0000, hi_cnt != 16'hFFFF};
      since_rst <= since_rst + {7'h00, since_rst != 8'hFF};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  a_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 6'h3F |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_status_onehot: assert property (reg_req.rd && reg_req.addr == `ADDR_STATUS
                                    |=> $onehot(reg_rdata[3:0]))
    else $error("status state field not one-hot");
  a_bus_sticky: assert property (bus_mode |=> bus_mode)
    else $error("bus mode left without reset");
  a_bus_released: assert property (bus_mode && $past(bus_mode, 3) |-> !sda_oe)
    else $error("pin still driven in bus mode");
  a_req_switch: assert property (low_cnt == REQ_CYCLES + 8 |-> bus_mode)
    else $error("long clock low did not switch to bus");
  a_switch_cause: assert property ($rose(bus_mode) |-> low_cnt > REQ_CYCLES || since_rst < 8'h28)
    else $error("bus mode entered without a request");
  a_drive_legal: assert property (sda_out |-> sda_oe)
    else $error("pin drive value high while not enabled");
  a_start_band: assert property ($fell(lvl) && since_rst == 8'hFF |-> hi_cnt >= P / 8)
    else $error("high time shorter than the start interval");
  a_init_quiet: assert property ($rose(nrst) |-> (!sda_oe && !bus_mode) [*8])
    else $error("pin used during initialisation");

  c_bus_entry: cover property ($rose(bus_mode));
  c_pulse_fall: cover property ($fell(lvl) && since_rst == 8'hFF);
  c_fatal_band: cover property (fatal_error_indication && $fell(lvl));
endmodule : temp_pwm_output_monitor

bind temp_pwm_output temp_pwm_output_monitor #(
  .PERIOD_LOG2(PERIOD_LOG2),
  .REQ_CYCLES (REQ_CYCLES)
) mon (
  .mclk                  (mclk),
  .nrst                  (nrst),
  .reg_req               (reg_req),
  .reg_rdata             (reg_rdata),
  .scl_in                (scl_in),
  .sda_in                (sda_in),
  .fatal_error_indication(fatal_error_indication),
  .sda_out               (sda_out),
  .sda_oe                (sda_oe),
  .bus_mode              (bus_mode)
);

// file: design/temp_pwm_output.sv
// Pulse-width and thermal relay output stage sharing one pin with a two-wire bus
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "temp_pwm_defs.svh"

module temp_pwm_output
  import temp_pwm_pkg::*;
#(
  parameter int PERIOD_LOG2 = `PERIOD_LOG2,
  parameter int REQ_CYCLES  = (`SWITCH_REQUEST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire reg_req_s    reg_req,
  output logic      [15:0] reg_rdata,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        fatal_error_indication,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             bus_mode
);

  localparam int DATA_SHIFT = PERIOD_LOG2 - 11;
  localparam int NUM_W      = 26;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Die range byte to a limit in 0.02 kelvin counts
  function automatic logic [15:0] die_limit(input logic [7:0] step);
    die_limit = `DIE_RANGE_BASE + {3'h0, step, 5'h00};
  endfunction : die_limit

  function automatic out_cfg_s decode_cfg(input logic [15:0] w);
    decode_cfg.select          = w[`CTRL_SELECT_MSB:`CTRL_SELECT_LSB];
    decode_cfg.drive_push_pull = w[`CTRL_DRIVE_TYPE_BIT];
    decode_cfg.relay_select    = w[`CTRL_RELAY_SELECT_BIT];
    decode_cfg.pulse_enable    = w[`CTRL_PULSE_ENABLE_BIT];
  endfunction : decode_cfg

  // --------------------------------------------------------------------------
  // Stored words
  // --------------------------------------------------------------------------
  // Stand-ins for the nonvolatile words: preset at power-up, kept through nrst
  logic [15:0] output_control_word = `RST_OUTPUT_CONTROL_WORD;
  logic [15:0] object_range_low    = `RST_OBJECT_RANGE_LOW;
  logic [15:0] object_range_high   = `RST_OBJECT_RANGE_HIGH;
  logic [15:0] die_range_word      = `RST_DIE_RANGE_WORD;
  logic [15:0] die_temperature;
  logic [15:0] object_temperature;

  // Working copies taken once after reset
  out_cfg_s    cfg;
  logic [15:0] cal_obj_low;
  logic [15:0] cal_obj_high;
  logic [15:0] cal_die_range;

  out_state_e  state;
  logic [4:0]  init_cnt;
  logic        scl_meta;
  logic        scl_sync;
  logic [$clog2(REQ_CYCLES+2)-1:0] low_cnt;
  logic [PERIOD_LOG2-1:0] phase;
  logic        fatal;
  logic        relay_level;

  logic [9:0]  calc_code;
  logic [9:0]  shown_code;
  logic        div_busy;
  logic [4:0]  div_step;
  logic [NUM_W-1:0] div_num;
  logic [16:0] div_rem;
  logic [15:0] div_den;

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  // No reset here: a reset must find the words written before it, as after a power cycle
  always_ff @(posedge mclk) begin
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `ADDR_OUTPUT_CONTROL_WORD: output_control_word <= reg_req.wdata;
        `ADDR_OBJECT_RANGE_LOW:    object_range_low    <= reg_req.wdata;
        `ADDR_OBJECT_RANGE_HIGH:   object_range_high   <= reg_req.wdata;
        `ADDR_DIE_RANGE_WORD:      die_range_word      <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      die_temperature     <= `RST_TEMPERATURE;
      object_temperature  <= `RST_TEMPERATURE;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        `ADDR_DIE_TEMPERATURE:     die_temperature     <= reg_req.wdata;
        `ADDR_OBJECT_TEMPERATURE:  object_temperature  <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `ADDR_OUTPUT_CONTROL_WORD: reg_rdata <= output_control_word;
        `ADDR_OBJECT_RANGE_LOW:    reg_rdata <= object_range_low;
        `ADDR_OBJECT_RANGE_HIGH:   reg_rdata <= object_range_high;
        `ADDR_DIE_RANGE_WORD:      reg_rdata <= die_range_word;
        `ADDR_DIE_TEMPERATURE:     reg_rdata <= die_temperature;
        `ADDR_OBJECT_TEMPERATURE:  reg_rdata <= object_temperature;
        `ADDR_STATUS:              reg_rdata <= {shown_code, relay_level, fatal, state};
        default:                   reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // Clock pin synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
    end
  end

  // Data line plays no part in the request; it is only relevant once the pin is
  // handed to the bus, which lives outside this block.
  logic unused_sda;
  assign unused_sda = sda_in;

  // --------------------------------------------------------------------------
  // Mode sequencing
  // --------------------------------------------------------------------------
  logic req_seen;
  assign req_seen = (low_cnt > REQ_CYCLES[$bits(low_cnt)-1:0]);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= '0;
    end else if (scl_sync || state == st_bus || state == st_init) begin
      low_cnt <= '0;
    end else if (!req_seen) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // Calibration is copied only here, so later writes act after the next reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      init_cnt      <= 5'h00;
      cfg           <= '0;
      cal_obj_low   <= `RST_OBJECT_RANGE_LOW;
      cal_obj_high  <= `RST_OBJECT_RANGE_HIGH;
      cal_die_range <= `RST_DIE_RANGE_WORD;
    end else if (state == st_init) begin
      init_cnt <= init_cnt + 1'b1;
      if (init_cnt == 5'(`INIT_CYCLES - 1)) begin
        cfg           <= decode_cfg(output_control_word);
        cal_obj_low   <= object_range_low;
        cal_obj_high  <= object_range_high;
        cal_die_range <= die_range_word;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= st_init;
    end else begin
      unique case (state)
        st_init: begin
          if (init_cnt == 5'(`INIT_CYCLES)) begin
            if (!cfg.pulse_enable) begin
              state <= st_bus;
            end else if (cfg.relay_select) begin
              state <= st_relay;
            end else begin
              state <= st_pulse;
            end
          end
        end
        st_pulse: begin
          if (req_seen) begin
            state <= st_bus;
          end
        end
        st_relay: begin
          if (req_seen) begin
            state <= st_bus;
          end
        end
        // Only a reset leaves bus mode
        st_bus: state <= st_bus;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Period counter and fatal flag
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase <= '0;
    end else if (state == st_pulse) begin
      phase <= phase + 1'b1;
    end else begin
      phase <= '0;
    end
  end

  // Sampled per period so a flag change never tears a pulse
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fatal <= 1'b0;
    end else if (phase == '0) begin
      fatal <= fatal_error_indication;
    end
  end

  // --------------------------------------------------------------------------
  // Rescaling to a 10-bit code
  // --------------------------------------------------------------------------
  logic        use_die;
  logic [15:0] sel_temp;
  logic [15:0] sel_low;
  logic [15:0] sel_high;

  // Codes 01 and 10 have no defined data; they fall back to die temperature
  assign use_die  = (cfg.select != 2'b11);
  assign sel_temp = use_die ? die_temperature : object_temperature;
  assign sel_low  = use_die ? die_limit(cal_die_range[7:0]) : cal_obj_low;
  assign sel_high = use_die ? die_limit(cal_die_range[15:8]) : cal_obj_high;

  logic [15:0] diff;
  logic [25:0] scaled;
  assign diff   = sel_temp - sel_low;
  // x*1023 = x*1024 - x
  assign scaled = {diff, 10'h000} - {10'h000, diff};

  logic [16:0] rem_shift;
  assign rem_shift = {div_rem[15:0], div_num[NUM_W-1]};

  // One division per period; result shown in the following period
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_busy  <= 1'b0;
      div_step  <= 5'h00;
      div_num   <= '0;
      div_rem   <= 17'h00000;
      div_den   <= 16'h0000;
      calc_code <= 10'h000;
    end else if (state == st_pulse && phase == '0) begin
      if (sel_high <= sel_low || sel_temp <= sel_low) begin
        calc_code <= 10'h000;
      end else if (sel_temp >= sel_high) begin
        calc_code <= `CODE_FULL_SCALE;
      end else begin
        div_busy <= 1'b1;
        div_step <= 5'h00;
        div_num  <= scaled;
        div_rem  <= 17'h00000;
        div_den  <= sel_high - sel_low;
      end
    end else if (div_busy) begin
      div_num  <= {div_num[NUM_W-2:0], 1'b0};
      div_step <= div_step + 1'b1;
      if (rem_shift >= {1'b0, div_den}) begin
        div_rem   <= rem_shift - {1'b0, div_den};
        calc_code <= {calc_code[8:0], 1'b1};
      end else begin
        div_rem   <= rem_shift;
        calc_code <= {calc_code[8:0], 1'b0};
      end
      if (div_step == 5'(NUM_W - 1)) begin
        div_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shown_code <= 10'h000;
    end else if (state == st_pulse && phase == '0 && !div_busy) begin
      shown_code <= calc_code;
    end
  end

  // --------------------------------------------------------------------------
  // Thermal relay comparator
  // --------------------------------------------------------------------------
  logic [16:0] relay_on_level;
  logic [16:0] relay_off_level;
  // Threshold shares the low object range word, hysteresis the high one
  assign relay_on_level  = {1'b0, cal_obj_low} + {1'b0, cal_obj_high};
  assign relay_off_level = {1'b0, cal_obj_low} - {1'b0, cal_obj_high};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      relay_level <= 1'b0;
    end else if (state == st_relay) begin
      if ({1'b0, object_temperature} >= relay_on_level) begin
        relay_level <= 1'b1;
      end else if (!relay_off_level[16] &&
                   {1'b0, object_temperature} <= relay_off_level) begin
        relay_level <= 1'b0;
      end else begin
        relay_level <= relay_level;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin driver
  // --------------------------------------------------------------------------
  logic [PERIOD_LOG2-1:0] start_end;
  logic [PERIOD_LOG2-1:0] data_end;
  logic [PERIOD_LOG2-1:0] error_end;
  assign start_end = PERIOD_LOG2'(1) << (PERIOD_LOG2 - 3);
  assign data_end  = start_end + (PERIOD_LOG2'(shown_code) << DATA_SHIFT);
  assign error_end = PERIOD_LOG2'(7) << (PERIOD_LOG2 - 3);

  logic next_level;
  always_comb begin
    next_level = 1'b0;
    if (state == st_relay) begin
      next_level = relay_level;
    end else if (state == st_pulse) begin
      if (fatal) begin
        next_level = (phase < error_end);
      end else begin
        next_level = (phase < data_end);
      end
    end
  end

  // Bus and init leave the pin released for the bus engine
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
      bus_mode <= 1'b0;
    end else begin
      bus_mode <= (state == st_bus);
      if (state == st_pulse || state == st_relay) begin
        sda_out <= cfg.drive_push_pull & next_level;
        sda_oe  <= cfg.drive_push_pull | ~next_level;
      end else begin
        sda_out <= 1'b0;
        sda_oe  <= 1'b0;
      end
    end
  end

endmodule : temp_pwm_output

// file: include/temp_pwm_defs.svh
// Offsets, field positions, reset values and timing counts of the temperature pulse output
`ifndef TEMP_PWM_DEFS_SVH
`define TEMP_PWM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------------
`define ADDR_OUTPUT_CONTROL_WORD 6'h02
`define ADDR_DIE_TEMPERATURE     6'h06
`define ADDR_OBJECT_TEMPERATURE  6'h07
`define ADDR_STATUS              6'h0F
`define ADDR_OBJECT_RANGE_HIGH   6'h20
`define ADDR_OBJECT_RANGE_LOW    6'h21
`define ADDR_DIE_RANGE_WORD      6'h23

// ----------------------------------------------------------------------------
// Fields of the output control word
// ----------------------------------------------------------------------------
`define CTRL_PULSE_ENABLE_BIT    0
`define CTRL_RELAY_SELECT_BIT    1
`define CTRL_DRIVE_TYPE_BIT      2
`define CTRL_SELECT_LSB          4
`define CTRL_SELECT_MSB          5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_OUTPUT_CONTROL_WORD  16'h0000
`define RST_OBJECT_RANGE_LOW     16'h0000
`define RST_OBJECT_RANGE_HIGH    16'hFFFF
`define RST_DIE_RANGE_WORD       16'hFF00
`define RST_TEMPERATURE          16'h0000

// ----------------------------------------------------------------------------
// Scaling constants
// ----------------------------------------------------------------------------
`define DIE_RANGE_BASE           16'h2DE4
`define DIE_RANGE_STEP_SHIFT     5
`define CODE_FULL_SCALE          10'h3FF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS            50
`define SWITCH_REQUEST_TIME_NS   1440000
`define INIT_CYCLES              16
`define PERIOD_LOG2              13

`endif

// file: include/temp_pwm_pkg.sv
// Types shared by the temperature pulse output
package temp_pwm_pkg;

  // --------------------------------------------------------------------------
  // Register port request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // --------------------------------------------------------------------------
  // Decoded output configuration
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] select;
    logic       drive_push_pull;
    logic       relay_select;
    logic       pulse_enable;
  } out_cfg_s;

  typedef enum logic [3:0] {
    st_init  = 4'b0001,
    st_pulse = 4'b0010,
    st_relay = 4'b0100,
    st_bus   = 4'b1000
  } out_state_e;

endpackage : temp_pwm_pkg
